// ===== common/tcc_pkg.sv
package tcc_pkg;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 16;
    // Register offsets.
    localparam logic [7:0] OFS_CCR = 8'h00;
    localparam logic [7:0] OFS_CMR = 8'h04;
    localparam logic [7:0] OFS_CV = 8'h10;
    localparam logic [7:0] OFS_RA = 8'h14;
    localparam logic [7:0] OFS_RB = 8'h18;
    localparam logic [7:0] OFS_RC = 8'h1c;
    localparam logic [7:0] OFS_SR = 8'h20;
    localparam logic [7:0] OFS_IMR = 8'h24;
    localparam logic [7:0] OFS_BCR = 8'hc0;
    localparam logic [7:0] OFS_BMR = 8'hc4;
    // Channel control and block control bits.
    localparam int CCR_CLOCK_ENABLE_CMD = 0;
    localparam int CCR_CLOCK_DISABLE_CMD = 1;
    localparam int CCR_SOFT_TRIGGER_CMD = 2;
    localparam int BCR_SYNC = 0;
    // Channel mode fields.
    localparam int CMR_CLKSEL = 0;
    localparam int CMR_CLOCK_INVERT = 3;
    localparam int CMR_BURST = 4;
    localparam int CMR_LOAD_B_STOP = 6;
    localparam int CMR_LOAD_B_DISABLE = 7;
    localparam int CMR_TRGEDG = 8;
    localparam int CMR_ABETRG = 10;
    localparam int CMR_EEVT = 10;
    localparam int CMR_EXTERNAL_TRIGGER_ENABLE = 12;
    localparam int CMR_COMPARE_C_TRIGGER_EN = 14;
    localparam int CMR_WAVE = 15;
    localparam int CMR_LOAD_A_EDGE = 16;
    localparam int CMR_LOAD_B_EDGE = 18;
    localparam int CMR_W = 20;
    localparam logic [19:0] CMR_RESET = 20'h00000;
    // Status bits.
    localparam int SR_COUNTER_OVERFLOW_FLAG = 0;
    localparam int SR_LOAD_OVERRUN_FLAG = 1;
    localparam int SR_CPCS = 4;
    localparam int SR_LDRAS = 5;
    localparam int SR_LDRBS = 6;
    localparam int SR_ETRGS = 7;
    localparam int SR_CLOCK_RUNNING_FLAG = 16;
    localparam int EVT_W = 8;
    // Prescaler taps for divide by 2, 8, 32 and 128.
    localparam int PRE_W = 7;
    localparam int TAP_DIV2 = 0;
    localparam int TAP_DIV8 = 2;
    localparam int TAP_DIV32 = 4;
    localparam int TAP_DIV128 = 6;
    localparam int SYNC_W = 9;
    localparam logic [2:0] DMA_GAP = 3'h7;

    typedef enum logic [1:0] {
        EDGE_NONE = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } tcc_edge_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } tcc_bus_s;
endpackage : tcc_pkg

// ===== hw/tcc_top.sv
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - 16-bit counter steps on count clock edges
// - wrap from all-ones sets overflow flag
// - trigger zeroes counter at next count edge
// - block mode chains pins or line A
// - clock select: three external, five internal
// - invert bit flips the counting edge
// - burst gate passes edges while high
// - enable/disable commands; running flag shows enable
// - load-B or compare-C auto disable clock
// - disabled clock ignores start and stop
// - trigger starts; load-B or compare-C stops
// - mode bit selects capture or waveform
// - software trigger command triggers channel
// - block sync bit triggers like software
// - compare C match may trigger
// - external trigger source per mode
// - line A edges load capture registers
// - capture A and B load alternately
// - unread reload overwrites, sets overrun
// - DMA moves captures, eight clocks apart
module tcc_top (
    input wire logic CLOCK, // Peripheral clock.
    input wire logic SYS_RST, // Synchronous reset, high.
    input wire logic [7:0] ADDR, // Register byte address.
    input wire logic [31:0] WDATA, // Write data.
    input wire logic WR, // Write strobe.
    input wire logic RD, // Read strobe.
    output logic [31:0] RDATA, // Read data, cycle after RD.
    input wire logic [2:0] EXT_CLOCK_PINS, // External clock pins.
    input wire logic [2:0] CHAIN_LINE_A, // Line A of other channels.
    input wire logic SLOW_CLOCK, // Slow clock tap.
    input wire logic IO_LINE_A_IN, // Line A pin level.
    output logic IO_LINE_A_OUT, // Line A drive value.
    output logic IO_LINE_A_OE, // Line A drive enable.
    input wire logic IO_LINE_B_IN, // Line B pin level.
    output logic IO_LINE_B_OUT, // Line B drive value.
    output logic IO_LINE_B_OE, // Line B drive enable.
    output logic INT, // Channel interrupt, level.
    output logic DMA_VALID, // One-cycle capture transfer.
    output logic DMA_SEL_B, // Transfer holds register B.
    output logic [15:0] DMA_DATA // Captured value.
);
    function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                      input logic fall);
        edge_hit = (sel[0] & rise) | (sel[1] & fall);
    endfunction : edge_hit

    ////////////////////////////////////////////////////////////////////////
    tcc_pkg::tcc_bus_s bus;
    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    logic [tcc_pkg::CMR_W-1:0] cmr;
    logic [2:0] bmr;
    logic [15:0] cv;
    logic [15:0] ra;
    logic [15:0] rb;
    logic [15:0] rc;
    logic [tcc_pkg::EVT_W-1:0] sr_evt;
    logic [tcc_pkg::EVT_W-1:0] imr;
    logic clk_en;
    logic running;
    logic trig_pend;
    logic a_pend;
    logic unread_a;
    logic unread_b;

    wire wr_ccr = bus.wr && bus.addr == tcc_pkg::OFS_CCR;
    wire wr_bcr = bus.wr && bus.addr == tcc_pkg::OFS_BCR;
    wire rd_sr = bus.rd && bus.addr == tcc_pkg::OFS_SR;
    wire rd_ra = bus.rd && bus.addr == tcc_pkg::OFS_RA;
    wire rd_rb = bus.rd && bus.addr == tcc_pkg::OFS_RB;
    wire cmd_en = wr_ccr && bus.wdata[tcc_pkg::CCR_CLOCK_ENABLE_CMD];
    wire cmd_dis = wr_ccr && bus.wdata[tcc_pkg::CCR_CLOCK_DISABLE_CMD];
    wire sw_trig = wr_ccr && bus.wdata[tcc_pkg::CCR_SOFT_TRIGGER_CMD];
    wire sync_trig = wr_bcr && bus.wdata[tcc_pkg::BCR_SYNC];

    wire wave = cmr[tcc_pkg::CMR_WAVE];
    wire [2:0] clk_sel = cmr[tcc_pkg::CMR_CLKSEL +: 3];
    wire [1:0] burst = cmr[tcc_pkg::CMR_BURST +: 2];
    wire [1:0] trg_edge = cmr[tcc_pkg::CMR_TRGEDG +: 2];
    wire [1:0] eevt = cmr[tcc_pkg::CMR_EEVT +: 2];
    wire [1:0] load_a_edge = cmr[tcc_pkg::CMR_LOAD_A_EDGE +: 2];
    wire [1:0] load_b_edge = cmr[tcc_pkg::CMR_LOAD_B_EDGE +: 2];
    wire ldb_stop = cmr[tcc_pkg::CMR_LOAD_B_STOP];
    wire ldb_dis = cmr[tcc_pkg::CMR_LOAD_B_DISABLE];

    ////////////////////////////////////////////////////////////////////////
    // Pins pass three flops; the filtered level only moves once the second
    // and third stages agree, which rejects a single-cycle glitch.
    logic [tcc_pkg::SYNC_W-1:0] s1;
    logic [tcc_pkg::SYNC_W-1:0] s2;
    logic [tcc_pkg::SYNC_W-1:0] s3;
    logic [tcc_pkg::SYNC_W-1:0] filt;
    logic [tcc_pkg::SYNC_W-1:0] filt_d;
    wire [tcc_pkg::SYNC_W-1:0] raw = {IO_LINE_B_IN, IO_LINE_A_IN, SLOW_CLOCK,
                                       CHAIN_LINE_A, EXT_CLOCK_PINS};
    wire [tcc_pkg::SYNC_W-1:0] rise = filt & ~filt_d;
    wire [tcc_pkg::SYNC_W-1:0] fall = ~filt & filt_d;

    always_ff @(posedge CLOCK) begin
        s1 <= raw;
        s2 <= s1;
        s3 <= s2;
        filt_d <= filt;
        if (SYS_RST) begin
            filt <= '0;
        end else begin
            filt <= (s2 == s3) ? s3 : filt;
        end
    end

    wire [2:0] pin_lv = filt[2:0];
    wire [2:0] chain_lv = filt[5:3];
    wire slow_lv = filt[6];
    wire la = filt[7];
    wire lb = filt[8];
    wire la_rise = rise[7];
    wire la_fall = fall[7];
    wire [2:0] xc = (bmr & chain_lv) | (~bmr & pin_lv);

    ////////////////////////////////////////////////////////////////////////
    // Count clock: the selected level is sampled here, so an external
    // clock must stay well below the peripheral clock to be seen.
    logic [tcc_pkg::PRE_W-1:0] pre;
    logic sel_lv;
    logic lv_d;
    logic [2:0] xc_d;
    always_comb begin
        unique case (clk_sel)
            3'h0: sel_lv = pre[tcc_pkg::TAP_DIV2];
            3'h1: sel_lv = pre[tcc_pkg::TAP_DIV8];
            3'h2: sel_lv = pre[tcc_pkg::TAP_DIV32];
            3'h3: sel_lv = pre[tcc_pkg::TAP_DIV128];
            3'h4: sel_lv = slow_lv;
            3'h5: sel_lv = xc[0];
            3'h6: sel_lv = xc[1];
            3'h7: sel_lv = xc[2];
        endcase
    end
    wire cnt_lv = sel_lv ^ cmr[tcc_pkg::CMR_CLOCK_INVERT];
    // Burst code zero leaves the gate open; codes one to three pick a selection.
    wire [3:0] gate_src = {xc, 1'b1};
    wire gate = gate_src[burst];
    wire cnt_edge = cnt_lv & ~lv_d & gate;
    wire step = cnt_edge && clk_en && running;
    wire [15:0] next_cv = trig_pend ? 16'h0000 : cv + 16'h0001;
    wire ovf = step && !trig_pend && cv == 16'hffff;
    wire cpc = step && wave && next_cv == rc;

    ////////////////////////////////////////////////////////////////////////
    // External trigger source follows the operating mode.
    wire [2:0] xc_fall = xc_d & ~xc;
    wire [2:0] xc_rs = xc & ~xc_d;
    logic ev_rise;
    logic ev_fall;
    always_comb begin
        if (!wave) begin
            ev_rise = cmr[tcc_pkg::CMR_ABETRG] ? rise[8] : la_rise;
            ev_fall = cmr[tcc_pkg::CMR_ABETRG] ? fall[8] : la_fall;
        end else if (eevt == 2'h0) begin
            ev_rise = rise[8];
            ev_fall = fall[8];
        end else begin
            ev_rise = xc_rs[eevt - 2'h1];
            ev_fall = xc_fall[eevt - 2'h1];
        end
    end
    wire ext_hit = edge_hit(trg_edge, ev_rise, ev_fall);
    wire ext_trig = ext_hit && (!wave || cmr[tcc_pkg::CMR_EXTERNAL_TRIGGER_ENABLE]);
    wire cpc_trig = cpc && cmr[tcc_pkg::CMR_COMPARE_C_TRIGGER_EN];
    wire trig = sw_trig || sync_trig || ext_trig || cpc_trig;

    ////////////////////////////////////////////////////////////////////////
    // Capture registers load alternately, A then B, on line A edges.
    wire ld_a = !wave && edge_hit(load_a_edge, la_rise, la_fall) && !a_pend;
    wire ld_b = !wave && edge_hit(load_b_edge, la_rise, la_fall) && a_pend
                && !ld_a;
    wire auto_dis = (ld_b && ldb_dis) || (cpc && cmr[tcc_pkg::CMR_LOAD_B_DISABLE]);
    wire auto_stop = (ld_b && ldb_stop) || (cpc && cmr[tcc_pkg::CMR_LOAD_B_STOP]);
    wire [tcc_pkg::EVT_W-1:0] evt_set = {ext_hit, ld_b, ld_a, cpc, 2'h0,
                                         (ld_a && unread_a) || (ld_b && unread_b),
                                         ovf};

    logic [2:0] gap;
    logic dma_pa;
    logic dma_pb;
    wire dma_go = gap == 3'h0 && (dma_pa || dma_pb);
    wire dma_a = dma_go && dma_pa;
    wire dma_b = dma_go && !dma_pa;

    always_ff @(posedge CLOCK) begin
        lv_d <= cnt_lv;
        xc_d <= xc;
        if (SYS_RST) begin
            pre <= '0;
            cmr <= tcc_pkg::CMR_RESET;
            bmr <= 3'h0;
            imr <= '0;
            rc <= 16'h0000;
            cv <= 16'h0000;
            ra <= 16'h0000;
            rb <= 16'h0000;
            sr_evt <= '0;
            clk_en <= 1'b0;
            running <= 1'b0;
            trig_pend <= 1'b0;
            a_pend <= 1'b0;
            unread_a <= 1'b0;
            unread_b <= 1'b0;
        end else begin
            pre <= pre + 7'h01;
            if (bus.wr && bus.addr == tcc_pkg::OFS_CMR) begin
                cmr <= bus.wdata[tcc_pkg::CMR_W-1:0];
            end
            if (bus.wr && bus.addr == tcc_pkg::OFS_BMR) begin
                bmr <= bus.wdata[2:0];
            end
            if (bus.wr && bus.addr == tcc_pkg::OFS_IMR) begin
                imr <= bus.wdata[tcc_pkg::EVT_W-1:0];
            end
            if (bus.wr && bus.addr == tcc_pkg::OFS_RC) begin
                rc <= bus.wdata[15:0];
            end
            // Disable wins over enable when both are written together.
            if (cmd_dis || auto_dis) begin
                clk_en <= 1'b0;
            end else if (cmd_en) begin
                clk_en <= 1'b1;
            end
            if (clk_en && trig) begin
                running <= 1'b1;
            end else if (clk_en && auto_stop) begin
                running <= 1'b0;
            end
            if (trig) begin
                trig_pend <= 1'b1;
            end else if (step) begin
                trig_pend <= 1'b0;
            end
            if (step) begin
                cv <= next_cv;
            end
            if (ld_a) begin
                ra <= cv;
            end
            if (ld_b) begin
                rb <= cv;
            end
            if (trig) begin
                a_pend <= 1'b0;
            end else if (ld_a || ld_b) begin
                a_pend <= ld_a;
            end
            unread_a <= ld_a || (unread_a && !rd_ra && !dma_a);
            unread_b <= ld_b || (unread_b && !rd_rb && !dma_b);
            // An event in the same cycle as the status read survives it.
            sr_evt <= evt_set | (rd_sr ? '0 : sr_evt);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read-out and DMA. The DMA only moves captures toward memory.
    logic [31:0] rd_mux;
    always_comb begin
        unique case (bus.addr)
            tcc_pkg::OFS_CMR: rd_mux = {12'h000, cmr};
            tcc_pkg::OFS_CV: rd_mux = {16'h0000, cv};
            tcc_pkg::OFS_RA: rd_mux = {16'h0000, ra};
            tcc_pkg::OFS_RB: rd_mux = {16'h0000, rb};
            tcc_pkg::OFS_RC: rd_mux = {16'h0000, rc};
            tcc_pkg::OFS_SR: rd_mux = {15'h0000, clk_en, 8'h00, sr_evt};
            tcc_pkg::OFS_IMR: rd_mux = {24'h000000, imr};
            tcc_pkg::OFS_BMR: rd_mux = {29'h00000000, bmr};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            RDATA <= 32'h00000000;
            INT <= 1'b0;
            gap <= 3'h0;
            dma_pa <= 1'b0;
            dma_pb <= 1'b0;
            DMA_VALID <= 1'b0;
            DMA_SEL_B <= 1'b0;
            DMA_DATA <= 16'h0000;
            IO_LINE_A_OE <= 1'b0;
            IO_LINE_B_OE <= 1'b0;
            IO_LINE_A_OUT <= 1'b0;
            IO_LINE_B_OUT <= 1'b0;
        end else begin
            RDATA <= bus.rd ? rd_mux : 32'h00000000;
            INT <= |(sr_evt & imr);
            dma_pa <= ld_a || (dma_pa && !dma_a);
            dma_pb <= ld_b || (dma_pb && !dma_b);
            gap <= dma_go ? tcc_pkg::DMA_GAP : gap - (gap != 3'h0 ? 3'h1 : 3'h0);
            DMA_VALID <= dma_go;
            DMA_SEL_B <= dma_b;
            DMA_DATA <= dma_a ? ra : (dma_b ? rb : DMA_DATA);
            // Waveform drive values are not generated here; lines idle low.
            IO_LINE_A_OE <= wave;
            IO_LINE_B_OE <= wave && eevt != 2'h0;
            IO_LINE_A_OUT <= 1'b0;
            IO_LINE_B_OUT <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_trig_zero: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        step && trig_pend |=> cv == 16'h0000) else $error("trigger did not zero");
    a_ovf_flag: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        step && !trig_pend && cv == 16'hffff |=> sr_evt[tcc_pkg::SR_COUNTER_OVERFLOW_FLAG] && cv == 0)
        else $error("overflow flag missing");
    a_enable_cmd: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        cmd_en && !cmd_dis && !auto_dis |=> clk_en) else $error("enable lost");
    a_dis_hold: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !clk_en && !cmd_en |=> $stable(cv) && $stable(running)) else $error("disabled moved");
    a_ldb_stop: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        clk_en && ld_b && ldb_stop && !trig |=> !running) else $error("no stop");
    a_sw_start: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (sw_trig || sync_trig) && clk_en |=> running && trig_pend) else $error("no start");
    a_load_alt: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        ld_a && !trig |=> a_pend) else $error("A load not recorded");
    a_capture_val: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        ld_a |=> ra == $past(cv)) else $error("capture value wrong");
    a_overrun: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        ld_b && unread_b |=> sr_evt[tcc_pkg::SR_LOAD_OVERRUN_FLAG]) else $error("overrun missed");
    a_dma_gap: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        DMA_VALID |=> !DMA_VALID [*7]) else $error("DMA spacing short");
    a_capture_b: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        ld_b |=> rb == $past(cv)) else $error("capture B value wrong");
    a_overrun_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        ld_a && unread_a |=> sr_evt[tcc_pkg::SR_LOAD_OVERRUN_FLAG]) else $error("overrun A missed");
    a_dma_data: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        dma_a |=> DMA_VALID && !DMA_SEL_B && DMA_DATA == $past(ra))
        else $error("DMA A word wrong");
    a_int_level: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        |(sr_evt & imr) |=> INT) else $error("interrupt missing");
endmodule : tcc_top

// ===== verification/tcc_src_model.sv
`timescale 1ns/1ps
module tcc_src_model (
    input wire logic clock, // Peripheral clock.
    output logic [2:0] ext_clock_pins, // External clock pins.
    output logic [2:0] chain_line_a, // Line A of other channels.
    output logic io_line_a, // Line A level.
    output logic io_line_b, // Line B level.
    output logic slow_clock // Slow clock tap level.
);
    logic [8:0] src = 9'h000;

    assign ext_clock_pins = src[2:0];
    assign chain_line_a = src[5:3];
    assign io_line_a = src[6];
    assign io_line_b = src[7];
    assign slow_clock = src[8];

    ////////////////////////////////////////////////////////////////////////
    // Every level is held four peripheral clocks, so each pulse is longer
    // than one clock and the source stays well under the 2.5 ratio limit.
    task automatic toggle(input int idx, input int n);
        repeat (n) begin
            @(posedge clock);
            src[idx] <= ~src[idx];
            repeat (3) @(posedge clock);
        end
    endtask : toggle

    task automatic set_level(input int idx, input logic v);
        @(posedge clock);
        src[idx] <= v;
        repeat (3) @(posedge clock);
    endtask : set_level
endmodule : tcc_src_model

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [2:0] ext_pins;
    logic [2:0] chain_a;
    logic line_a;
    logic line_b;
    logic slow;
    logic a_oe;
    logic b_oe;
    logic a_out;
    logic b_out;
    logic irq;
    logic dma_valid;
    logic dma_sel_b;
    logic [15:0] dma_data;
    logic [16:0] dma_q[$];
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    int last_dma = -100;

    tcc_src_model u_src (
        .clock(clock),
        .ext_clock_pins(ext_pins),
        .chain_line_a(chain_a),
        .io_line_a(line_a),
        .io_line_b(line_b),
        .slow_clock(slow)
    );

    tcc_top u_dut (
        .CLOCK(clock),
        .SYS_RST(sys_rst),
        .ADDR(addr),
        .WDATA(wdata),
        .WR(wr),
        .RD(rd),
        .RDATA(rdata),
        .EXT_CLOCK_PINS(ext_pins),
        .CHAIN_LINE_A(chain_a),
        .SLOW_CLOCK(slow),
        .IO_LINE_A_IN(line_a),
        .IO_LINE_A_OUT(a_out),
        .IO_LINE_A_OE(a_oe),
        .IO_LINE_B_IN(line_b),
        .IO_LINE_B_OUT(b_out),
        .IO_LINE_B_OE(b_oe),
        .INT(irq),
        .DMA_VALID(dma_valid),
        .DMA_SEL_B(dma_sel_b),
        .DMA_DATA(dma_data)
    );

    initial begin
        forever #25 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        d = rdata;
    endtask : bus_rd

    // Pin edges reach the counter a few clocks late, hence the settle wait.
    task automatic cnt(input int idx, input int n, input logic [15:0] exp);
        logic [31:0] v;
        u_src.toggle(idx, n);
        repeat (8) @(posedge clock);
        bus_rd(tcc_pkg::OFS_CV, v);
        chk("counter value", {16'h0000, exp}, v);
    endtask : cnt

    // Capture loads hand their value to the transfer port; spacing is judged here.
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (dma_valid === 1'b1) begin
            chk("dma spacing", 32'h1, {31'h0, (cyc - last_dma) >= 8});
            last_dma = cyc;
            dma_q.push_back({dma_sel_b, dma_data});
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] v;
        bus_rd(tcc_pkg::OFS_CMR, v);
        chk("mode reset", 32'h0, v);
        bus_rd(tcc_pkg::OFS_SR, v);
        chk("status reset", 32'h0, v);
        bus_wr(tcc_pkg::OFS_CV, 32'h00001234);
        bus_rd(tcc_pkg::OFS_CV, v);
        chk("counter read only", 32'h0, v);
        bus_rd(8'h0c, v);
        chk("unmapped read", 32'h0, v);
        chk("interrupt idle", 32'h0, {31'h0, irq});
    endtask : t_reset

    task automatic t_select();
        logic [31:0] v;
        logic [31:0] w;
        // A trigger only starts an enabled clock, so enable goes first.
        for (int i = 0; i < 4; i++) begin
            bus_wr(tcc_pkg::OFS_CMR, i < 3 ? 32'h5 + i : 32'h4);
            bus_wr(tcc_pkg::OFS_CCR, 32'h1);
            bus_wr(tcc_pkg::OFS_CCR, 32'h4);
            cnt(i < 3 ? i : 8, 6, 16'h0002);
        end
        // Two reads one tap period apart always straddle exactly one rising edge.
        for (int k = 0; k < 4; k++) begin
            bus_wr(tcc_pkg::OFS_CMR, k);
            bus_rd(tcc_pkg::OFS_CV, v);
            repeat ((2 << (2 * k)) - 2) @(posedge clock);
            bus_rd(tcc_pkg::OFS_CV, w);
            chk("internal tap step", 32'h1, w - v);
        end
    endtask : t_select

    task automatic t_invert();
        bus_wr(tcc_pkg::OFS_CMR, 32'h0000000d);
        repeat (6) @(posedge clock);
        bus_wr(tcc_pkg::OFS_CCR, 32'h4);
        cnt(0, 3, 16'h0000);
        cnt(0, 1, 16'h0001);
    endtask : t_invert

    task automatic t_enable();
        logic [31:0] v;
        bus_wr(tcc_pkg::OFS_CMR, 32'h5);
        bus_wr(tcc_pkg::OFS_CCR, 32'h2);
        bus_rd(tcc_pkg::OFS_SR, v);
        chk("clock running", 32'h0, v & 32'h10000);
        bus_wr(tcc_pkg::OFS_CCR, 32'h4);
        cnt(0, 4, 16'h0001);
        bus_wr(tcc_pkg::OFS_CCR, 32'h5);
        cnt(0, 4, 16'h0001);
        bus_rd(tcc_pkg::OFS_SR, v);
        chk("clock running", 32'h10000, v & 32'h10000);
    endtask : t_enable

    task automatic t_sync_chain_burst();
        cnt(0, 4, 16'h0003);
        bus_wr(tcc_pkg::OFS_BCR, 32'h1);
        cnt(0, 2, 16'h0000);
        bus_wr(tcc_pkg::OFS_BMR, 32'h1);
        bus_wr(tcc_pkg::OFS_CCR, 32'h4);
        cnt(0, 4, 16'h0000);
        cnt(3, 4, 16'h0001);
        bus_wr(tcc_pkg::OFS_BMR, 32'h0);
        bus_wr(tcc_pkg::OFS_CMR, 32'h25);
        bus_wr(tcc_pkg::OFS_CCR, 32'h4);
        cnt(0, 4, 16'h0001);
        u_src.set_level(1, 1'b1);
        cnt(0, 6, 16'h0002);
        u_src.set_level(1, 1'b0);
    endtask : t_sync_chain_burst

    task automatic t_ext_trigger();
        for (int k = 0; k < 2; k++) begin
            bus_wr(tcc_pkg::OFS_CMR, 32'h105 | (k << 10));
            u_src.toggle(6 + k, 2);
            cnt(0, 2, 16'h0000);
            cnt(0, 2, 16'h0001);
        end
    endtask : t_ext_trigger

    task automatic t_capture();
        logic [31:0] v;
        bus_wr(tcc_pkg::OFS_IMR, 32'h20);
        bus_wr(tcc_pkg::OFS_CMR, 32'h00090045);
        bus_wr(tcc_pkg::OFS_CCR, 32'h5);
        cnt(0, 6, 16'h0002);
        bus_rd(tcc_pkg::OFS_SR, v);
        u_src.toggle(6, 1);
        repeat (8) @(posedge clock);
        chk("interrupt raised", 32'h1, {31'h0, irq});
        cnt(0, 4, 16'h0004);
        u_src.toggle(6, 1);
        cnt(0, 4, 16'h0004);
        bus_rd(tcc_pkg::OFS_RA, v);
        chk("capture first", 32'h2, v);
        bus_rd(tcc_pkg::OFS_RB, v);
        chk("capture second", 32'h4, v);
        bus_rd(tcc_pkg::OFS_SR, v);
        chk("load flags", 32'h60, v & 32'h60);
        repeat (2) @(posedge clock);
        chk("interrupt cleared", 32'h0, {31'h0, irq});
        chk("dma count", 32'h2, dma_q.size());
        chk("dma first", 32'h00002, {15'h0, dma_q[0]});
        chk("dma second", 32'h10004, {15'h0, dma_q[1]});
    endtask : t_capture

    task automatic t_mode();
        logic [31:0] v;
        chk("line a enable", 32'h0, {31'h0, a_oe});
        bus_wr(tcc_pkg::OFS_CMR, 32'h00008000);
        repeat (3) @(posedge clock);
        chk("line a enable", 32'h1, {31'h0, a_oe});
        chk("line b enable", 32'h0, {31'h0, b_oe});
        bus_wr(tcc_pkg::OFS_CMR, 32'h00008400);
        repeat (3) @(posedge clock);
        chk("line b enable", 32'h1, {31'h0, b_oe});
        chk("line drive idle", 32'h0, {30'h0, a_out, b_out});
        // With compare C at three the count restarts before it can pass three.
        bus_wr(tcc_pkg::OFS_RC, 32'h3);
        bus_wr(tcc_pkg::OFS_CMR, 32'h0000c000);
        bus_wr(tcc_pkg::OFS_CCR, 32'h4);
        repeat (40) @(posedge clock);
        bus_rd(tcc_pkg::OFS_SR, v);
        chk("compare flag", 32'h10, v & 32'h10);
        bus_rd(tcc_pkg::OFS_CV, v);
        chk("compare restart", 32'h1, {31'h0, v <= 32'h3});
        bus_wr(tcc_pkg::OFS_CMR, 32'h0);
    endtask : t_mode

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset();
        t_select();
        t_invert();
        t_enable();
        t_sync_chain_burst();
        t_ext_trigger();
        t_capture();
        t_mode();
        close_out();
    end

    initial begin
        repeat (30000) @(posedge clock);
        fails++;
        close_out();
    end
endmodule : tb_top
